// File: rtl/ahp_map.svh
// Constants of the arithmetic unit host port
`ifndef AHP_MAP_SVH
`define AHP_MAP_SVH

`define AHP_BYTE_BITS 8
`define AHP_WORD_BITS 16
`define AHP_STACK_WORDS 8
`define AHP_STACK_BYTES 16
`define AHP_PTR_BITS 4

`define AHP_CMD_SVC_BIT 7

`define AHP_STAT_BUSY_BIT 7
`define AHP_STAT_SVC_BIT 6
`define AHP_STAT_END_BIT 5
`define AHP_STAT_PTR_LSB 0

`define AHP_SYNC_BITS 5
`define AHP_SY_CS 0
`define AHP_SY_RD 1
`define AHP_SY_WR 2
`define AHP_SY_DACK 3
`define AHP_SY_SACK 4
`define AHP_SYNC_IDLE 5'h1F

`endif

// File: rtl/ahp_pkg.sv
// Types of the arithmetic unit host port
`include "ahp_map.svh"

package ahp_pkg;

    typedef enum logic [4:0] {
        AHP_IDLE = 5'h01,
        AHP_RD_WAIT = 5'h02,
        AHP_RD_HOLD = 5'h04,
        AHP_WR_WAIT = 5'h08,
        AHP_WR_HOLD = 5'h10
    } ahp_state_t;

    typedef struct packed {
        logic [`AHP_SYNC_BITS-1:0] sync1;
        logic [`AHP_SYNC_BITS-1:0] sync2;
        ahp_state_t state;
        logic armed;
        logic busy;
        logic end_flag;
        logic svc_flag;
        logic cmd_start;
        logic [`AHP_BYTE_BITS-1:0] cmd_code;
        logic [`AHP_BYTE_BITS-1:0] rd_data;
    } ahp_port_st_t;

    typedef struct packed {
        logic [`AHP_STACK_BYTES-1:0][`AHP_BYTE_BITS-1:0] mem;
        logic [`AHP_PTR_BITS-1:0] ptr;
    } ahp_stack_st_t;

endpackage

// File: rtl/ahp_stack.sv
// Operand stack, 8 words of 16 bits, byte port and word port
`timescale 1ns/1ps
`include "ahp_map.svh"

module ahp_stack (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic byte_push,
    input wire logic byte_pop,
    input wire logic [`AHP_BYTE_BITS-1:0] byte_in,
    output logic [`AHP_BYTE_BITS-1:0] byte_out,
    input wire logic word_push,
    input wire logic word_pop,
    input wire logic word_load,
    input wire logic [`AHP_WORD_BITS-1:0] word_in,
    output logic [`AHP_WORD_BITS-1:0] stack_top,
    output logic [`AHP_WORD_BITS-1:0] stack_second,
    output logic [`AHP_PTR_BITS-1:0] byte_ptr
);

    ahp_pkg::ahp_stack_st_t r;
    ahp_pkg::ahp_stack_st_t next_r;

    // Pointer arithmetic wraps around the 16 byte ring
    function automatic logic [`AHP_PTR_BITS-1:0] ptr_off(
        input logic [`AHP_PTR_BITS-1:0] p,
        input logic [`AHP_PTR_BITS-1:0] k
    );
        ptr_off = p - k;
    endfunction

    // Last byte pushed is read first: MS byte of a result leaves first
    assign byte_out = r.mem[ptr_off(r.ptr, 4'h1)];
    // Host pushes LS byte first, so a word is the higher byte on top
    assign stack_top = {r.mem[ptr_off(r.ptr, 4'h1)],
                        r.mem[ptr_off(r.ptr, 4'h2)]};
    assign stack_second = {r.mem[ptr_off(r.ptr, 4'h3)],
                           r.mem[ptr_off(r.ptr, 4'h4)]};
    assign byte_ptr = r.ptr;

    always_comb begin
        next_r = r;
        // Core word port has priority; both ports share one pointer
        if (word_push) begin
            next_r.mem[r.ptr] = word_in[7:0];
            next_r.mem[ptr_off(r.ptr, 4'hF)] = word_in[15:8];
            next_r.ptr = ptr_off(r.ptr, 4'hE);
        end else if (word_pop) begin
            next_r.ptr = ptr_off(r.ptr, 4'h2);
        end else if (word_load) begin
            next_r.mem[ptr_off(r.ptr, 4'h2)] = word_in[7:0];
            next_r.mem[ptr_off(r.ptr, 4'h1)] = word_in[15:8];
        end else if (byte_push) begin
            next_r.mem[r.ptr] = byte_in;
            next_r.ptr = ptr_off(r.ptr, 4'hF);
        end else if (byte_pop) begin
            next_r.ptr = ptr_off(r.ptr, 4'h1);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    default clocking stk_cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    stack_lifo_a: assert property (
        byte_push && !word_push && !word_pop && !word_load
        |=> byte_out == $past(byte_in))
        else $error("pushed byte is not on top of the stack");

endmodule

// File: rtl/ahp_host_port.sv
// Host port of the stack arithmetic unit: handshake, flags, stack
`timescale 1ns/1ps
`include "ahp_map.svh"

module ahp_host_port (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic cmd_sel,
    input wire logic [`AHP_BYTE_BITS-1:0] host_bus_in,
    output logic [`AHP_BYTE_BITS-1:0] host_bus_out,
    output logic host_bus_oe,
    output logic pause_n,
    output logic done_out,
    output logic done_oe,
    input wire logic done_ack_n,
    output logic service_req,
    input wire logic service_ack_n,
    output logic cmd_start,
    output logic [`AHP_BYTE_BITS-1:0] cmd_code,
    input wire logic exec_done,
    input wire logic core_push,
    input wire logic core_pop,
    input wire logic core_load,
    input wire logic [`AHP_WORD_BITS-1:0] core_word,
    output logic [`AHP_WORD_BITS-1:0] stack_top,
    output logic [`AHP_WORD_BITS-1:0] stack_second
);

    ahp_pkg::ahp_port_st_t r;
    ahp_pkg::ahp_port_st_t next_r;

    logic cs_lo;
    logic rd_lo;
    logic wr_lo;
    logic dack_lo;
    logic sack_lo;
    logic finish;
    logic clr_end;
    logic push_byte;
    logic pop_byte;
    logic raw_req;
    logic [`AHP_BYTE_BITS-1:0] pop_data;
    logic [`AHP_PTR_BITS-1:0] byte_ptr;
    logic [`AHP_BYTE_BITS-1:0] status;

    ahp_stack u_stack (
        .core_clk(core_clk),
        .resetn(resetn),
        .byte_push(push_byte),
        .byte_pop(pop_byte),
        .byte_in(host_bus_in),
        .byte_out(pop_data),
        .word_push(core_push),
        .word_pop(core_pop),
        .word_load(core_load),
        .word_in(core_word),
        .stack_top(stack_top),
        .stack_second(stack_second),
        .byte_ptr(byte_ptr)
    );

    // Only the second stage is used; the first may be metastable
    assign cs_lo = !r.sync2[`AHP_SY_CS];
    assign rd_lo = !r.sync2[`AHP_SY_RD];
    assign wr_lo = !r.sync2[`AHP_SY_WR];
    assign dack_lo = !r.sync2[`AHP_SY_DACK];
    assign sack_lo = !r.sync2[`AHP_SY_SACK];

    assign finish = exec_done && r.busy;

    always_comb begin
        status = '0;
        status[`AHP_STAT_BUSY_BIT] = r.busy;
        status[`AHP_STAT_SVC_BIT] = r.svc_flag;
        status[`AHP_STAT_END_BIT] = r.end_flag;
        status[`AHP_STAT_PTR_LSB +: `AHP_PTR_BITS] = byte_ptr;
    end

    // Raw request closes the gap before the synchroniser catches up,
    // so a fast host cannot see pause high before the access is taken
    assign raw_req = !cs_n && (rd_n != wr_n) && r.armed;

    always_comb begin
        pause_n = 1'b1;
        case (r.state)
            ahp_pkg::AHP_IDLE: pause_n = !raw_req;
            ahp_pkg::AHP_RD_WAIT: pause_n = 1'b0;
            ahp_pkg::AHP_WR_WAIT: pause_n = 1'b0;
            default: pause_n = 1'b1;
        endcase
    end

    always_comb begin
        next_r = r;
        next_r.sync1 = {service_ack_n, done_ack_n, wr_n, rd_n, cs_n};
        next_r.sync2 = r.sync1;
        next_r.cmd_start = 1'b0;
        clr_end = 1'b0;
        push_byte = 1'b0;
        pop_byte = 1'b0;
        if (finish) begin
            next_r.busy = 1'b0;
        end
        case (r.state)
            ahp_pkg::AHP_IDLE: begin
                if (!cs_lo) begin
                    next_r.armed = 1'b1;
                end
                // Both strobes low is undefined and is not taken
                if (cs_lo && r.armed && rd_lo && !wr_lo) begin
                    next_r.armed = 1'b0;
                    next_r.state = ahp_pkg::AHP_RD_WAIT;
                end else if (cs_lo && r.armed && wr_lo && !rd_lo) begin
                    next_r.armed = 1'b0;
                    next_r.state = ahp_pkg::AHP_WR_WAIT;
                end
            end
            ahp_pkg::AHP_RD_WAIT: begin
                clr_end = 1'b1;
                if (cmd_sel) begin
                    next_r.rd_data = status;
                end else begin
                    next_r.rd_data = pop_data;
                    pop_byte = 1'b1;
                end
                next_r.state = ahp_pkg::AHP_RD_HOLD;
            end
            ahp_pkg::AHP_RD_HOLD: begin
                if (!rd_lo) begin
                    next_r.state = ahp_pkg::AHP_IDLE;
                end
            end
            ahp_pkg::AHP_WR_WAIT: begin
                if (!cmd_sel) begin
                    push_byte = 1'b1;
                    next_r.state = ahp_pkg::AHP_WR_HOLD;
                end else if (!r.busy || finish) begin
                    next_r.cmd_code = host_bus_in;
                    next_r.cmd_start = 1'b1;
                    next_r.busy = 1'b1;
                    next_r.state = ahp_pkg::AHP_WR_HOLD;
                end
            end
            ahp_pkg::AHP_WR_HOLD: begin
                if (!wr_lo) begin
                    clr_end = 1'b1;
                    next_r.state = ahp_pkg::AHP_IDLE;
                end
            end
            default: next_r.state = ahp_pkg::AHP_IDLE;
        endcase
        // Completion wins over a clear in the same cycle, so a polling
        // host cannot lose the flag; this also makes the pulse case
        if (dack_lo || clr_end) begin
            next_r.end_flag = 1'b0;
        end
        if (finish) begin
            next_r.end_flag = 1'b1;
        end
        if (sack_lo) begin
            next_r.svc_flag = 1'b0;
        end
        if (finish) begin
            // Bit 7 set raises it, bit 7 clear drops it
            next_r.svc_flag = r.cmd_code[`AHP_CMD_SVC_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
            r.sync1 <= `AHP_SYNC_IDLE;
            r.sync2 <= `AHP_SYNC_IDLE;
            r.state <= ahp_pkg::AHP_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign host_bus_out = r.rd_data;
    assign host_bus_oe = (r.state == ahp_pkg::AHP_RD_HOLD);
    // Open drain: only ever pulls low
    assign done_out = 1'b0;
    assign done_oe = r.end_flag;
    assign service_req = r.svc_flag;
    assign cmd_start = r.cmd_start;
    assign cmd_code = r.cmd_code;

    default clocking port_cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    end_set_a: assert property (finish |=> done_oe)
        else $error("END not asserted after completion");

    end_ack_a: assert property (
        dack_lo && !exec_done |=> !done_oe)
        else $error("END not released by end acknowledge");

    end_pulse_a: assert property (
        dack_lo && finish ##1 dack_lo && !exec_done
        |-> done_oe ##1 !done_oe)
        else $error("END pulse not one clock wide");

    rd_clear_a: assert property (
        r.state == ahp_pkg::AHP_RD_WAIT && !exec_done |=> !done_oe)
        else $error("read did not release END");

    wr_clear_a: assert property (
        r.state == ahp_pkg::AHP_WR_HOLD && !wr_lo && !exec_done
        |=> !done_oe)
        else $error("write did not release END");

    svc_set_a: assert property (
        finish && r.cmd_code[`AHP_CMD_SVC_BIT] |=> service_req)
        else $error("service request not raised");

    svc_auto_a: assert property (
        finish && !r.cmd_code[`AHP_CMD_SVC_BIT] |=> !service_req)
        else $error("service request not cleared by plain command");

    svc_ack_a: assert property (
        sack_lo && !exec_done |=> !service_req)
        else $error("service request not cleared by acknowledge");

    cs_gate_a: assert property (
        r.state == ahp_pkg::AHP_IDLE && !cs_lo
        |=> r.state == ahp_pkg::AHP_IDLE)
        else $error("access taken without chip select");

    rd_ready_a: assert property (
        r.state == ahp_pkg::AHP_RD_WAIT |=> pause_n && host_bus_oe)
        else $error("pause released without data on the bus");

    rd_hold_a: assert property (
        host_bus_oe && rd_lo |=> host_bus_oe && $stable(host_bus_out))
        else $error("read data dropped while strobe low");

    busy_pause_a: assert property (
        r.state == ahp_pkg::AHP_WR_WAIT && cmd_sel && r.busy && !exec_done
        |-> !pause_n ##1 !pause_n)
        else $error("pause released while command busy");

    busy_clear_a: assert property (
        finish && !(r.state == ahp_pkg::AHP_WR_WAIT && cmd_sel)
        |=> !r.busy)
        else $error("busy not cleared at completion");

    wr_ready_a: assert property (
        r.state == ahp_pkg::AHP_WR_HOLD |-> pause_n)
        else $error("pause still low after the write was taken");

    pause_quiet_a: assert property (
        r.state == ahp_pkg::AHP_IDLE && cs_n |-> pause_n)
        else $error("pause pulled low without chip select");

    data_push_a: assert property (
        r.state == ahp_pkg::AHP_WR_WAIT && !cmd_sel
        |=> r.state == ahp_pkg::AHP_WR_HOLD && !cmd_start)
        else $error("data write not pushed at once");

    cmd_take_a: assert property (
        r.state == ahp_pkg::AHP_WR_WAIT && cmd_sel && (!r.busy || finish)
        |=> cmd_start && cmd_code == $past(host_bus_in))
        else $error("command byte not latched");

    start_once_a: assert property (
        cmd_start |-> r.busy ##1 !cmd_start)
        else $error("command start not a single pulse");

    rd_status_a: assert property (
        r.state == ahp_pkg::AHP_RD_WAIT && cmd_sel
        |=> host_bus_out == $past(status))
        else $error("status read returned wrong byte");

    rd_pop_a: assert property (
        r.state == ahp_pkg::AHP_RD_WAIT && !cmd_sel
        |=> host_bus_out == $past(pop_data))
        else $error("data read did not return the top byte");

    pop_ptr_a: assert property (
        r.state == ahp_pkg::AHP_RD_WAIT && !cmd_sel
        && !core_push && !core_pop && !core_load
        |=> byte_ptr == $past(byte_ptr) - 4'h1)
        else $error("data read did not pop one byte");

    both_low_a: assert property (
        r.state == ahp_pkg::AHP_IDLE && rd_lo && wr_lo
        |=> r.state == ahp_pkg::AHP_IDLE)
        else $error("access taken with both strobes low");

    rearm_a: assert property (
        r.state == ahp_pkg::AHP_IDLE && !r.armed
        |=> r.state == ahp_pkg::AHP_IDLE)
        else $error("access taken without a fresh select");

    svc_hold_a: assert property (
        service_req && !sack_lo && !finish |=> service_req)
        else $error("service request dropped without acknowledge");

    end_hold_a: assert property (
        done_oe && !dack_lo && r.state == ahp_pkg::AHP_IDLE |=> done_oe)
        else $error("END released without a cause");

    bus_release_a: assert property (
        r.state == ahp_pkg::AHP_RD_HOLD && !rd_lo |=> !host_bus_oe)
        else $error("data bus still driven after the read");

    cover_read_c: cover property (
        r.state == ahp_pkg::AHP_RD_WAIT ##1 host_bus_oe ##[1:20] !host_bus_oe);
    cover_cmd_c: cover property (cmd_start ##[1:50] finish);
    cover_busy_c: cover property (
        r.state == ahp_pkg::AHP_WR_WAIT && r.busy && cmd_sel ##[1:50] cmd_start);
    cover_pulse_c: cover property (dack_lo && finish ##1 !exec_done);
    cover_svc_c: cover property (
        finish && r.cmd_code[`AHP_CMD_SVC_BIT] ##[1:50] sack_lo);

endmodule

// File: bench/ahp_host_model.sv
// Host bus master model driving the arithmetic unit host port
`timescale 1ns/1ps
`include "ahp_map.svh"

module ahp_host_model (
    input wire logic core_clk,
    input wire logic pause_n,
    input wire logic [`AHP_BYTE_BITS-1:0] host_bus_out,
    input wire logic host_bus_oe,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic cmd_sel,
    output logic [`AHP_BYTE_BITS-1:0] host_bus_in,
    output logic saw_low,
    output logic stuck,
    output logic hold_bad
);
    logic [`AHP_BYTE_BITS-1:0] bus_seen;

    // Undriven bus reads as the inverse, so a missing enable shows up
    assign bus_seen = host_bus_oe ? host_bus_out : ~host_bus_out;

    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        cmd_sel = 1'b0;
        host_bus_in = 8'h00;
        saw_low = 1'b0;
        stuck = 1'b0;
        hold_bad = 1'b0;
    end

    // One access with its own select fall
    task automatic access(input logic wr, input logic cd,
                          input logic [7:0] wdata, output logic [7:0] rdata);
        int n;
        n = 0;
        @(posedge core_clk);
        cs_n <= 1'b0;
        cmd_sel <= cd;
        host_bus_in <= wdata;
        @(posedge core_clk);
        if (wr) begin
            wr_n <= 1'b0;
        end else begin
            rd_n <= 1'b0;
        end
        saw_low = 1'b0;
        stuck = 1'b0;
        hold_bad = 1'b0;
        // Strobe and select held while pause is low
        do begin
            @(posedge core_clk);
            n++;
            if (pause_n === 1'b0) saw_low = 1'b1;
        end while (pause_n !== 1'b1 && n < 100);
        stuck = (n >= 100);
        rdata = bus_seen;
        if (!wr) begin
            repeat (2) @(posedge core_clk);
            if (bus_seen !== rdata) hold_bad = 1'b1;
        end
        wr_n <= 1'b1;
        rd_n <= 1'b1;
        @(posedge core_clk);
        cs_n <= 1'b1;
        // Released bus shows no stale value
        host_bus_in <= ~wdata;
        repeat (3) @(posedge core_clk);
    endtask

    // Write strobe without chip select
    task automatic stray();
        @(posedge core_clk);
        host_bus_in <= 8'hE7;
        wr_n <= 1'b0;
        repeat (8) begin
            @(posedge core_clk);
            if (pause_n === 1'b0) saw_low = 1'b1;
        end
        wr_n <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask
endmodule

// File: bench/arith_unit_host_port_tb.sv
// Self-checking testbench of the arithmetic unit host port
`timescale 1ns/1ps

module arith_unit_host_port_tb;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic done_ack_n = 1'b1;
    logic service_ack_n = 1'b1;
    logic exec_done = 1'b0;
    logic core_push = 1'b0;
    logic core_pop = 1'b0;
    logic core_load = 1'b0;
    logic [15:0] core_word = 16'h0000;
    logic cs_n, rd_n, wr_n, cmd_sel, host_bus_oe, pause_n;
    logic done_out, done_oe, service_req, cmd_start;
    logic [7:0] host_bus_in, host_bus_out, cmd_code, rd;
    logic [15:0] stack_top, stack_second;
    int n_mismatch = 0;
    int tests_run = 0;
    int n_start = 0;
    int n_done_hi = 0;
    int n0;

    ahp_host_model host (.core_clk(core_clk), .pause_n(pause_n),
        .host_bus_oe(host_bus_oe),
        .host_bus_out(host_bus_out), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .cmd_sel(cmd_sel), .host_bus_in(host_bus_in), .saw_low(),
        .stuck(), .hold_bad());

    ahp_host_port uut (.core_clk(core_clk), .resetn(resetn), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .cmd_sel(cmd_sel),
        .host_bus_in(host_bus_in), .host_bus_out(host_bus_out),
        .host_bus_oe(host_bus_oe), .pause_n(pause_n), .done_out(done_out),
        .done_oe(done_oe), .done_ack_n(done_ack_n),
        .service_req(service_req), .service_ack_n(service_ack_n),
        .cmd_start(cmd_start), .cmd_code(cmd_code), .exec_done(exec_done),
        .core_push(core_push), .core_pop(core_pop), .core_load(core_load),
        .core_word(core_word), .stack_top(stack_top),
        .stack_second(stack_second));

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (cmd_start === 1'b1) n_start++;
        if (done_oe === 1'b1) n_done_hi++;
    end

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr_b(input logic cd, input logic [7:0] d);
        host.access(1'b1, cd, d, rd);
        check("write stuck", host.stuck, 0);
    endtask

    task automatic rd_b(input logic cd);
        host.access(1'b0, cd, 8'h00, rd);
        check("read pause", {host.saw_low, host.stuck}, 2);
        check("read hold", host.hold_bad, 0);
        check("read oe off", host_bus_oe, 0);
    endtask

    task automatic done_pulse();
        @(posedge core_clk);
        exec_done <= 1'b1;
        @(posedge core_clk);
        exec_done <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic t_reset();
        check("end after reset", {done_oe, done_out}, 0);
        check("svc after reset", service_req, 0);
        rd_b(1'b1);
        check("status", rd, 16'h0000);
    endtask

    // Core word port op: bits are push, pop, load
    task automatic core_op(input logic [2:0] op, input logic [15:0] w);
        @(posedge core_clk);
        {core_push, core_pop, core_load} <= op;
        core_word <= w;
        @(posedge core_clk);
        {core_push, core_pop, core_load} <= 3'h0;
        @(posedge core_clk);
    endtask

    task automatic t_stack();
        logic [7:0] b [4] = '{8'h01, 8'h80, 8'h5A, 8'hC3};
        for (int i = 0; i < 4; i++) wr_b(1'b0, b[i]);
        check("top", stack_top, 16'hC35A);
        check("second", stack_second, 16'h8001);
        rd_b(1'b1);
        check("ptr", rd, 16'h0004);
        for (int i = 3; i >= 0; i--) begin
            rd_b(1'b0);
            check("pop", rd, b[i]);
        end
        core_op(3'h4, 16'hA55A);
        check("word top", stack_top, 16'hA55A);
        core_op(3'h4, 16'h1111);
        core_op(3'h1, 16'h7E81);
        check("load top", stack_top, 16'h7E81);
        check("load second", stack_second, 16'hA55A);
        core_op(3'h2, 16'h0000);
        check("pop top", stack_top, 16'hA55A);
        rd_b(1'b0);
        check("word hi", rd, 16'h00A5);
        rd_b(1'b0);
        check("word lo", rd, 16'h005A);
    endtask

    task automatic t_flags();
        n0 = n_start;
        wr_b(1'b1, 8'hAC);
        rd_b(1'b1);
        check("busy", rd[7], 1);
        done_pulse();
        check("starts", 16'(n_start - n0), 1);
        check("code", cmd_code, 16'h00AC);
        check("end set", done_oe, 1);
        check("svc set", service_req, 1);
        done_ack_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        done_ack_n <= 1'b1;
        check("end ack", done_oe, 0);
        service_ack_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        service_ack_n <= 1'b1;
        check("svc ack", service_req, 0);
        wr_b(1'b1, 8'h91);
        done_pulse();
        rd_b(1'b1);
        check("status flags", rd[7:6], 1);
        check("status end", rd[5], 1);
        repeat (3) @(posedge core_clk);
        check("end read clr", done_oe, 0);
        wr_b(1'b1, 8'h11);
        done_pulse();
        check("svc auto clr", service_req, 0);
        check("end pending", done_oe, 1);
        wr_b(1'b0, 8'h3C);
        repeat (3) @(posedge core_clk);
        check("end write clr", done_oe, 0);
    endtask

    task automatic t_pulse();
        // Acknowledge tied low leaves only a short pulse
        done_ack_n <= 1'b0;
        wr_b(1'b1, 8'h2A);
        n0 = n_done_hi;
        done_pulse();
        repeat (4) @(posedge core_clk);
        check("end pulse", 16'(n_done_hi - n0), 1);
        done_ack_n <= 1'b1;
    endtask

    task automatic t_busy();
        n0 = n_start;
        wr_b(1'b1, 8'h01);
        fork
            wr_b(1'b1, 8'h82);
            begin
                repeat (20) @(posedge core_clk);
                check("pause busy", pause_n, 0);
                check("held start", 16'(n_start - n0), 1);
                done_pulse();
            end
        join
        check("code 2", cmd_code, 16'h0082);
        done_pulse();
        check("svc 2", service_req, 1);
    endtask

    task automatic t_nocs();
        n0 = n_start;
        host.saw_low = 1'b0;
        host.stray();
        check("no cs pause", host.saw_low, 0);
        check("no cs start", 16'(n_start - n0), 0);
        rd_b(1'b1);
        check("no cs ptr", rd[3:0], 1);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #300000;
        n_mismatch++;
        end_of_test();
    end

    initial begin
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (6) @(posedge core_clk);
        t_reset();
        t_stack();
        t_flags();
        t_pulse();
        t_busy();
        t_nocs();
        end_of_test();
    end
endmodule
